/* File: design/aio_ctrl_pkg.sv */
package aio_ctrl_pkg;

  // bus map, byte offsets
  localparam logic [4:0] OFF_RESULT     = 5'h00;
  localparam logic [4:0] OFF_SW_START   = 5'h01;
  localparam logic [4:0] OFF_GAIN0      = 5'h02;
  localparam logic [4:0] OFF_WINDOW     = 5'h06;
  localparam logic [4:0] OFF_OVERSAMPLE = 5'h07;
  localparam logic [4:0] OFF_OUT0_LO    = 5'h0C;
  localparam logic [4:0] OFF_OUT0_HI    = 5'h0D;
  localparam logic [4:0] OFF_OUT1_LO    = 5'h0E;
  localparam logic [4:0] OFF_OUT1_HI    = 5'h0F;
  localparam logic [4:0] OFF_OUT_CFG    = 5'h10;
  localparam logic [4:0] OFF_START_CFG  = 5'h11;
  localparam int         GAIN_REGS      = 4;

  // field positions
  localparam int FIRST_LSB   = 0;
  localparam int LAST_LSB    = 4;
  localparam int SIMUL_BIT   = 0;
  localparam int SRC_LSB_BIT = 0;
  localparam int SRC_MSB_BIT = 1;
  localparam int SCAN_BIT    = 2;
  localparam int POL_BIT     = 3;
  localparam int CT0_SEL_BIT = 4;

  localparam logic [1:0] SRC_SOFT  = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXT   = 2'h2;

  localparam logic [7:0]  BYTE_RST  = 8'h00;
  localparam logic [11:0] CODE_RST  = 12'h000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [15:0] CT_TERM   = 16'h0001;

  // result store
  localparam int RESULT_W   = 16;
  localparam int OUT_W      = 12;
  localparam int FIFO_DEPTH = 1024;
  localparam int FIFO_AW    = 10;
  localparam logic [FIFO_AW:0] FIFO_FULL_CNT = 11'h400;

  // counter time base
  localparam int CLK_HZ      = 20_000_000;
  localparam int CT_CLK_HZ   = 10_000_000;
  localparam int CT_TICK_DIV = CLK_HZ / CT_CLK_HZ;
  localparam int TICK_W      = (CT_TICK_DIV > 1) ? $clog2(CT_TICK_DIV) : 1;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(CT_TICK_DIV - 1);

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETUP, SEQ_ISSUE, SEQ_WAIT} seq_state_t;

endpackage

/* File: design/result_ram.sv */
`timescale 1ns/1ns
module result_ram
  import aio_ctrl_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                wr_en,
  input  wire logic [FIFO_AW-1:0]  wr_addr,
  input  wire logic [RESULT_W-1:0] wr_data,
  input  wire logic [FIFO_AW-1:0]  rd_addr,
  output logic      [RESULT_W-1:0] rd_data
);

  logic [RESULT_W-1:0] mem [FIFO_DEPTH];

  always_ff @(posedge clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always from a register
  always_ff @(posedge clk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

/* File: design/analog_io_ctrl.sv */
`timescale 1ns/1ns
module analog_io_ctrl
  import aio_ctrl_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_b,
  input  wire logic [4:0]          bus_addr,
  input  wire logic                bus_wr,
  input  wire logic                bus_rd,
  input  wire logic                bus_word,
  input  wire logic [15:0]         bus_wdata,
  output logic      [15:0]         bus_rdata,
  output logic                     bus_rvalid,
  output logic                     conv_start,
  output logic      [3:0]          conv_channel,
  output logic      [1:0]          conv_gain,
  input  wire logic                conv_done,
  input  wire logic [RESULT_W-1:0] conv_data,
  output logic      [OUT_W-1:0]    out0_code,
  output logic      [OUT_W-1:0]    out1_code,
  input  wire logic                ext_trigger,
  input  wire logic                counter0_ext_clk,
  input  wire logic [15:0]         ct1_divisor,
  input  wire logic [15:0]         ct2_divisor,
  output logic                     counter2_out,
  output logic      [15:0]         counter0_value,
  output logic                     result_available,
  output logic                     fifo_full,
  output logic                     seq_busy
);

  function automatic logic byte_hit(input logic [4:0] addr, input logic word, input logic [4:0] off);
    byte_hit = (addr == off) || (word && off[0] && (addr == {off[4:1], 1'b0}));
  endfunction

  function automatic logic [7:0] byte_of(input logic [4:0] addr, input logic [15:0] data, input logic [4:0] off);
    byte_of = (addr == off) ? data[7:0] : data[15:8];
  endfunction

  // register write decode
  wire wr_sw_start = bus_wr && byte_hit(bus_addr, bus_word, OFF_SW_START);
  wire wr_window   = bus_wr && byte_hit(bus_addr, bus_word, OFF_WINDOW);
  wire wr_os       = bus_wr && byte_hit(bus_addr, bus_word, OFF_OVERSAMPLE);
  wire wr_out0_lo  = bus_wr && byte_hit(bus_addr, bus_word, OFF_OUT0_LO);
  wire wr_out0_hi  = bus_wr && byte_hit(bus_addr, bus_word, OFF_OUT0_HI);
  wire wr_out1_lo  = bus_wr && byte_hit(bus_addr, bus_word, OFF_OUT1_LO);
  wire wr_out1_hi  = bus_wr && byte_hit(bus_addr, bus_word, OFF_OUT1_HI);
  wire wr_out_cfg  = bus_wr && byte_hit(bus_addr, bus_word, OFF_OUT_CFG);
  wire wr_start    = bus_wr && byte_hit(bus_addr, bus_word, OFF_START_CFG);
  wire [7:0] window_wbyte = byte_of(bus_addr, bus_wdata, OFF_WINDOW);

  logic [7:0]          gain_reg [GAIN_REGS];
  logic [GAIN_REGS-1:0] gain_wr;
  logic [7:0]          window_reg;
  logic [7:0]          oversample_field;
  logic [7:0]          out_cfg_reg;
  logic [7:0]          start_cfg_reg;
  logic [7:0]          out0_lo_reg;
  logic [7:0]          out1_lo_reg;
  logic [OUT_W-1:0]    out0_pend_reg;
  logic [OUT_W-1:0]    out0_code_reg;
  logic [OUT_W-1:0]    out1_code_reg;

  for (genvar g = 0; g < GAIN_REGS; g++)
  begin : gain_bank
    assign gain_wr[g] = bus_wr && byte_hit(bus_addr, bus_word, 5'(OFF_GAIN0 + g));
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        gain_reg[g] <= BYTE_RST;
      else if (gain_wr[g])
        gain_reg[g] <= byte_of(bus_addr, bus_wdata, 5'(OFF_GAIN0 + g));
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      window_reg       <= BYTE_RST;
      oversample_field <= BYTE_RST;
      out_cfg_reg      <= BYTE_RST;
      start_cfg_reg    <= BYTE_RST;
      out0_lo_reg      <= BYTE_RST;
      out1_lo_reg      <= BYTE_RST;
    end
    else
    begin
      if (wr_window)  window_reg       <= byte_of(bus_addr, bus_wdata, OFF_WINDOW);
      if (wr_os)      oversample_field <= byte_of(bus_addr, bus_wdata, OFF_OVERSAMPLE);
      if (wr_out_cfg) out_cfg_reg      <= byte_of(bus_addr, bus_wdata, OFF_OUT_CFG);
      if (wr_start)   start_cfg_reg    <= byte_of(bus_addr, bus_wdata, OFF_START_CFG);
      if (wr_out0_lo) out0_lo_reg      <= byte_of(bus_addr, bus_wdata, OFF_OUT0_LO);
      if (wr_out1_lo) out1_lo_reg      <= byte_of(bus_addr, bus_wdata, OFF_OUT1_LO);
    end
  end

  wire [3:0] first_channel     = window_reg[FIRST_LSB +: 4];
  wire [3:0] last_channel      = window_reg[LAST_LSB +: 4];
  wire       simul             = out_cfg_reg[SIMUL_BIT];
  wire       trigger_src_lsb   = start_cfg_reg[SRC_LSB_BIT];
  wire       trigger_src_msb   = start_cfg_reg[SRC_MSB_BIT];
  wire [1:0] trigger_src       = {trigger_src_msb, trigger_src_lsb};
  wire       scan_select       = start_cfg_reg[SCAN_BIT];
  wire       trigger_polarity  = start_cfg_reg[POL_BIT];
  wire       counter0_clock_select = start_cfg_reg[CT0_SEL_BIT];
  wire       src_timer         = (trigger_src == SRC_TIMER);
  wire       src_ext           = (trigger_src == SRC_EXT);

  // output converter codes; low byte of a word write is taken directly
  wire [7:0]       out0_lo_now = wr_out0_lo ? byte_of(bus_addr, bus_wdata, OFF_OUT0_LO) : out0_lo_reg;
  wire [7:0]       out1_lo_now = wr_out1_lo ? byte_of(bus_addr, bus_wdata, OFF_OUT1_LO) : out1_lo_reg;
  wire [7:0]       out0_hi_b   = byte_of(bus_addr, bus_wdata, OFF_OUT0_HI);
  wire [7:0]       out1_hi_b   = byte_of(bus_addr, bus_wdata, OFF_OUT1_HI);
  wire [OUT_W-1:0] new0        = {out0_hi_b[3:0], out0_lo_now};
  wire [OUT_W-1:0] new1        = {out1_hi_b[3:0], out1_lo_now};
  wire [OUT_W-1:0] out0_code_next = (wr_out0_hi && !simul) ? new0 :
                                    (wr_out1_hi && simul) ? out0_pend_reg : out0_code_reg;
  wire [OUT_W-1:0] out1_code_next = wr_out1_hi ? new1 : out1_code_reg;
  wire [OUT_W-1:0] out0_pend_next = wr_out0_hi ? new0 : out0_pend_reg;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      out0_pend_reg <= CODE_RST;
      out0_code_reg <= CODE_RST;
      out1_code_reg <= CODE_RST;
    end
    else
    begin
      out0_pend_reg <= out0_pend_next;
      out0_code_reg <= out0_code_next;
      out1_code_reg <= out1_code_next;
    end
  end

  assign out0_code = out0_code_reg;
  assign out1_code = out1_code_reg;

  // pin synchronisers and counter time base
  logic [TICK_W-1:0] tick_cnt_reg;
  logic [1:0]        ext_sync_reg;
  logic [2:0]        ct0_sync_reg;
  logic [15:0]       ct0_cnt_reg;
  logic [15:0]       ct1_cnt_reg;
  logic [15:0]       ct2_cnt_reg;
  logic              ct2_out_reg;
  logic              ct2_prev_reg;

  wire ct_tick   = (tick_cnt_reg == TICK_LAST);
  wire ct_run    = ct_tick && (!src_ext || ext_sync_reg[1]);
  wire ct1_pulse = ct_run && (ct1_cnt_reg <= CT_TERM);
  wire ct2_wrap  = ct1_pulse && (ct2_cnt_reg <= CT_TERM);
  wire ct0_step  = counter0_clock_select ? (ct0_sync_reg[1] && !ct0_sync_reg[2]) : ct_tick;
  wire trig_edge = trigger_polarity ? (ct2_prev_reg && !ct2_out_reg) : (!ct2_prev_reg && ct2_out_reg);
  wire trig_event = trig_edge && (src_timer || src_ext);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt_reg <= '0;
      ext_sync_reg <= 2'h0;
      ct0_sync_reg <= 3'h0;
      ct0_cnt_reg  <= WORD_ZERO;
      ct1_cnt_reg  <= WORD_ZERO;
      ct2_cnt_reg  <= WORD_ZERO;
      ct2_out_reg  <= 1'b0;
      ct2_prev_reg <= 1'b0;
    end
    else
    begin
      tick_cnt_reg <= ct_tick ? '0 : tick_cnt_reg + 1'b1;
      ext_sync_reg <= {ext_sync_reg[0], ext_trigger};
      ct0_sync_reg <= {ct0_sync_reg[1:0], counter0_ext_clk};
      if (ct0_step) ct0_cnt_reg <= ct0_cnt_reg + 16'h0001;
      if (ct_run) ct1_cnt_reg <= ct1_pulse ? ct1_divisor : ct1_cnt_reg - 16'h0001;
      if (ct1_pulse) ct2_cnt_reg <= ct2_wrap ? ct2_divisor : ct2_cnt_reg - 16'h0001;
      if (ct2_wrap) ct2_out_reg <= !ct2_out_reg;
      ct2_prev_reg <= ct2_out_reg;
    end
  end

  assign counter0_value = ct0_cnt_reg;
  assign counter2_out   = ct2_out_reg;

  // conversion sequencer
  seq_state_t state_reg;
  logic [3:0] chan_reg;
  logic [3:0] single_ptr_reg;
  logic [7:0] os_left_reg;
  logic [1:0] conv_gain_reg;

  wire        start_event = wr_sw_start || trig_event;
  wire [7:0]  gain_flat_lo = gain_reg[0];
  wire [31:0] gain_flat = {gain_reg[3], gain_reg[2], gain_reg[1], gain_flat_lo};
  wire [1:0]  gain_sel  = gain_flat[{chan_reg, 1'b0} +: 2];
  wire        last_sample = (os_left_reg == BYTE_RST);
  wire        at_last     = (chan_reg == last_channel);

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg      <= SEQ_IDLE;
      chan_reg       <= 4'h0;
      single_ptr_reg <= 4'h0;
      os_left_reg    <= BYTE_RST;
      conv_gain_reg  <= 2'h0;
    end
    else
    begin
      conv_gain_reg <= gain_sel;
      if (wr_window) single_ptr_reg <= window_wbyte[FIRST_LSB +: 4];
      unique case (state_reg)
        SEQ_IDLE:
          if (start_event)
          begin
            chan_reg    <= scan_select ? first_channel : single_ptr_reg;
            os_left_reg <= oversample_field;
            state_reg   <= SEQ_SETUP;
          end
        SEQ_SETUP:
          state_reg <= SEQ_ISSUE;
        SEQ_ISSUE:
          state_reg <= SEQ_WAIT;
        SEQ_WAIT:
          if (conv_done)
          begin
            if (!last_sample)
            begin
              os_left_reg <= os_left_reg - 8'h01;
              state_reg   <= SEQ_ISSUE;
            end
            else if (scan_select && !at_last)
            begin
              chan_reg    <= chan_reg + 4'h1;
              os_left_reg <= oversample_field;
              state_reg   <= SEQ_SETUP;
            end
            else
            begin
              if (!scan_select && !wr_window)
                single_ptr_reg <= at_last ? first_channel : chan_reg + 4'h1;
              state_reg <= SEQ_IDLE;
            end
          end
      endcase
    end
  end

  assign conv_start   = (state_reg == SEQ_ISSUE);
  assign conv_channel = chan_reg;
  assign conv_gain    = conv_gain_reg;
  assign seq_busy     = (state_reg != SEQ_IDLE);

  // result store and host read port
  logic [FIFO_AW-1:0]  wr_ptr_reg;
  logic [FIFO_AW-1:0]  rd_ptr_reg;
  logic [FIFO_AW:0]    count_reg;
  logic                q_fresh_reg;
  logic [RESULT_W-1:0] fifo_q;
  logic [15:0]         rdata_reg;
  logic                rvalid_reg;

  wire rd_word0 = bus_rd && bus_word && (bus_addr == OFF_RESULT);
  wire rd_lo    = bus_rd && !bus_word && (bus_addr == OFF_RESULT);
  wire rd_hi    = bus_rd && !bus_word && (bus_addr == OFF_SW_START);
  wire pop      = (rd_word0 || rd_hi) && q_fresh_reg;
  wire push     = conv_done && (state_reg == SEQ_WAIT) && (count_reg != FIFO_FULL_CNT);
  wire [FIFO_AW:0] count_next = count_reg + {{FIFO_AW{1'b0}}, push} - {{FIFO_AW{1'b0}}, pop};
  wire [15:0] rdata_next = !q_fresh_reg ? WORD_ZERO :
                           rd_word0 ? fifo_q :
                           rd_lo ? {BYTE_RST, fifo_q[7:0]} :
                           rd_hi ? {BYTE_RST, fifo_q[15:8]} : WORD_ZERO;

  result_ram u_result_ram (
    .clk     (clk),
    .wr_en   (push),
    .wr_addr (wr_ptr_reg),
    .wr_data (conv_data),
    .rd_addr (rd_ptr_reg),
    .rd_data (fifo_q)
  );

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wr_ptr_reg  <= '0;
      rd_ptr_reg  <= '0;
      count_reg   <= '0;
      q_fresh_reg <= 1'b0;
      rdata_reg   <= WORD_ZERO;
      rvalid_reg  <= 1'b0;
    end
    else
    begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop)  rd_ptr_reg <= rd_ptr_reg + 1'b1;
      count_reg   <= count_next;
      q_fresh_reg <= (count_reg != '0) && !pop;
      if (bus_rd) rdata_reg <= rdata_next;
      rvalid_reg  <= bus_rd;
    end
  end

  assign bus_rdata        = rdata_reg;
  assign bus_rvalid       = rvalid_reg;
  assign result_available = q_fresh_reg;
  assign fifo_full        = (count_reg == FIFO_FULL_CNT);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  chk_word_result: assert property ((rd_word0 && q_fresh_reg) |=> bus_rdata == $past(fifo_q) && bus_rvalid)
    else $error("word read did not return the head result");
  chk_low_no_pop: assert property (rd_lo |=> rd_ptr_reg == $past(rd_ptr_reg))
    else $error("low byte read advanced the result store");
  chk_high_pop: assert property ((rd_hi && q_fresh_reg) |=> rd_ptr_reg == $past(rd_ptr_reg) + 1'b1)
    else $error("high byte read did not advance the result store");
  chk_sw_start: assert property ((wr_sw_start && state_reg == SEQ_IDLE) |-> ##2 conv_start ##1 !conv_start)
    else $error("software start did not give one conversion");
  chk_scan_first: assert property ((start_event && scan_select && state_reg == SEQ_IDLE && !wr_window && !wr_start)
    |-> ##2 conv_channel == $past(first_channel, 2))
    else $error("scan did not begin at first channel");
  chk_gain_apply: assert property ((conv_start && !$past(|gain_wr)) |-> conv_gain == gain_sel)
    else $error("conversion gain does not match its channel");
  chk_oversample: assert property ((state_reg == SEQ_WAIT && conv_done && !last_sample)
    |=> conv_start && $stable(chan_reg))
    else $error("oversample did not repeat the channel");
  chk_scan_end: assert property ((state_reg == SEQ_WAIT && conv_done && last_sample && at_last) |=> !seq_busy)
    else $error("scan ran past last channel");
  chk_trig_start: assert property ((trig_event && state_reg == SEQ_IDLE) |=> state_reg == SEQ_SETUP)
    else $error("trigger edge did not start conversion");
  chk_soft_ignore: assert property ((trig_edge && !src_timer && !src_ext && !wr_sw_start && !seq_busy)
    |=> !seq_busy)
    else $error("trigger edge started conversion in software mode");
  chk_out0_now: assert property ((wr_out0_hi && !simul) |=> out0_code == $past(new0))
    else $error("output 0 did not update on write");
  chk_out0_held: assert property ((wr_out0_hi && simul && !wr_out1_hi) |=> $stable(out0_code))
    else $error("output 0 changed while held");
  chk_out1_now: assert property (wr_out1_hi |=> out1_code == $past(new1))
    else $error("output 1 did not update on write");

  cov_scan_done: cover property (state_reg == SEQ_WAIT && conv_done && scan_select && at_last && last_sample);
  cov_byte_pair: cover property (rd_lo && q_fresh_reg ##1 !bus_rd ##1 rd_hi && q_fresh_reg);
  cov_simul_upd: cover property (wr_out0_hi && simul ##[1:20] wr_out1_hi);
  cov_timer_go:  cover property (trig_event && src_timer && !seq_busy);

endmodule

/* File: sim/conv_model.sv */
`timescale 1ns/1ns
module conv_model
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        conv_start,
  input  wire logic [3:0]  conv_channel,
  input  wire logic [1:0]  conv_gain,
  input  wire logic        slow,
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  logic [7:0] seq_reg;
  logic [2:0] wait_reg;
  logic [5:0] tag_reg;

  // result carries sample number, gain and channel so the bench can predict it
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      seq_reg   <= 8'h00;
      wait_reg  <= 3'h0;
      tag_reg   <= 6'h00;
      conv_done <= 1'b0;
      conv_data <= 16'h5A5A;
    end
    else
    begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start)
      begin
        wait_reg <= slow ? 3'h5 : 3'h1;
        tag_reg  <= {conv_gain, conv_channel};
      end
      else if (wait_reg != 3'h0)
        wait_reg <= wait_reg - 3'h1;
      if (!conv_start && wait_reg == 3'h1)
      begin
        conv_done <= 1'b1;
        conv_data <= {seq_reg, 2'b00, tag_reg};
        seq_reg   <= seq_reg + 8'h01;
      end
    end
  end
endmodule

/* File: sim/analog_io_register_control_tb.sv */
`timescale 1ns/1ns
module analog_io_register_control_tb;
  import aio_ctrl_pkg::*;
  logic              clk;
  logic              rst_b;
  logic [4:0]        bus_addr;
  logic              bus_wr;
  logic              bus_rd;
  logic              bus_word;
  logic [15:0]       bus_wdata;
  logic [15:0]       bus_rdata;
  logic              bus_rvalid;
  logic              conv_start;
  logic [3:0]        conv_channel;
  logic [1:0]        conv_gain;
  logic              conv_done;
  logic [15:0]       conv_data;
  logic [OUT_W-1:0]  out0_code;
  logic [OUT_W-1:0]  out1_code;
  logic              ext_trigger;
  logic              slow;
  logic              counter0_ext_clk;
  logic [15:0]       counter0_value;
  logic              counter2_out;
  logic              result_available;
  logic              fifo_full;
  logic              seq_busy;
  int                failures;
  int                checks;
  logic [5:0]        starts[$];

  analog_io_ctrl dut (.clk(clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_word(bus_word), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid),
    .conv_start(conv_start), .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_done(conv_done),
    .conv_data(conv_data), .out0_code(out0_code), .out1_code(out1_code), .ext_trigger(ext_trigger),
    .counter0_ext_clk(counter0_ext_clk), .ct1_divisor(16'h0002), .ct2_divisor(16'h0002),
    .counter2_out(counter2_out), .counter0_value(counter0_value), .result_available(result_available),
    .fifo_full(fifo_full), .seq_busy(seq_busy));
  conv_model model (.clk(clk), .rst_b(rst_b), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_gain(conv_gain), .slow(slow), .conv_done(conv_done), .conv_data(conv_data));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
    if (conv_start === 1'b1)
      starts.push_back({conv_gain, conv_channel});

  task automatic report_and_stop;
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic cmp_cnt(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi)
    begin
      failures++;
      $display("unexpected at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  task automatic hang(input int n);
    if (n == 0)
    begin
      failures++;
      $display("unexpected at %0t: wait ran out", $time);
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d, input logic w);
    @(negedge clk);
    bus_addr  = a;
    bus_wdata = d;
    bus_word  = w;
    bus_wr    = 1'b1;
    @(negedge clk);
    bus_wr = 1'b0;
  endtask

  // read answer comes back with the valid pulse; idle cycles after a pop
  task automatic rd(input logic [4:0] a, input logic w, input logic [15:0] exp);
    int n;
    @(negedge clk);
    bus_addr = a;
    bus_word = w;
    bus_rd   = 1'b1;
    @(negedge clk);
    bus_rd = 1'b0;
    n = 4;
    while (bus_rvalid !== 1'b1 && n > 0)
    begin
      @(negedge clk);
      n--;
    end
    hang(n);
    cmp16(bus_rdata, exp);
    repeat (3) @(negedge clk);
  endtask

  task automatic wait_idle;
    int n;
    n = 300;
    repeat (3) @(negedge clk);
    while (seq_busy !== 1'b0 && n > 0)
    begin
      @(negedge clk);
      n--;
    end
    hang(n);
    repeat (4) @(negedge clk);
  endtask

  task automatic test_single;
    wr(OFF_GAIN0, 16'hE41B, 1'b1);
    wr(5'h04, 16'h0000, 1'b1);
    wr(OFF_WINDOW, 16'h0055, 1'b0);
    wr(OFF_OVERSAMPLE, 16'h0001, 1'b0);
    wr(OFF_START_CFG, 16'h0000, 1'b0);
    starts.delete();
    wr(OFF_SW_START, 16'h00FF, 1'b0);
    wait_idle();
    cmp_cnt(starts.size(), 2, 2);
    cmp16({10'h000, starts[0]}, 16'h0015);
    cmp16({10'h000, starts[1]}, 16'h0015);
    cmp16({15'h0000, result_available}, 16'h0001);
    rd(OFF_RESULT, 1'b1, 16'h0015);
    rd(OFF_RESULT, 1'b1, 16'h0115);
    cmp16({15'h0000, result_available}, 16'h0000);
  endtask

  task automatic test_scan;
    slow = 1'b1;
    wr(OFF_WINDOW, 16'h0076, 1'b0);
    wr(OFF_OVERSAMPLE, 16'h0000, 1'b0);
    wr(OFF_START_CFG, 16'h0004, 1'b0);
    starts.delete();
    wr(OFF_RESULT, 16'h0000, 1'b1);
    wait_idle();
    cmp_cnt(starts.size(), 2, 2);
    cmp16({10'h000, starts[0]}, 16'h0026);
    cmp16({10'h000, starts[1]}, 16'h0037);
    rd(OFF_RESULT, 1'b0, 16'h0026);
    rd(OFF_RESULT, 1'b0, 16'h0026);
    rd(OFF_SW_START, 1'b0, 16'h0002);
    rd(OFF_RESULT, 1'b0, 16'h0037);
    rd(OFF_SW_START, 1'b0, 16'h0003);
    slow = 1'b0;
  endtask

  task automatic test_outputs;
    wr(OFF_OUT_CFG, 16'h0000, 1'b0);
    wr(OFF_OUT0_LO, 16'h0034, 1'b0);
    wr(OFF_OUT0_HI, 16'h00F2, 1'b0);
    @(negedge clk);
    cmp16({4'h0, out0_code}, 16'h0234);
    wr(OFF_OUT1_LO, 16'h0ABC, 1'b1);
    @(negedge clk);
    cmp16({4'h0, out1_code}, 16'h0ABC);
    wr(OFF_OUT_CFG, 16'h0001, 1'b0);
    wr(OFF_OUT0_LO, 16'h0311, 1'b1);
    @(negedge clk);
    cmp16({4'h0, out0_code}, 16'h0234);
    wr(OFF_OUT1_LO, 16'h0056, 1'b0);
    wr(OFF_OUT1_HI, 16'h0004, 1'b0);
    @(negedge clk);
    cmp16({4'h0, out0_code}, 16'h0311);
    cmp16({4'h0, out1_code}, 16'h0456);
  endtask

  task automatic test_trigger;
    logic [7:0] cfg[5];
    logic       trig[5];
    int         lo[5];
    cfg  = '{8'h01, 8'h09, 8'h00, 8'h02, 8'h02};
    trig = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    lo   = '{6, 6, 0, 0, 6};
    for (int i = 0; i < 5; i++)
    begin
      ext_trigger = trig[i];
      wr(OFF_START_CFG, {8'h00, cfg[i]}, 1'b0);
      repeat (10) @(negedge clk);
      starts.delete();
      repeat (200) @(negedge clk);
      cmp_cnt(starts.size(), lo[i], (lo[i] == 0) ? 0 : 14);
    end
  endtask

  // divisors of 2 give a counter 2 toggle every 8 clocks
  task automatic test_counters;
    logic [15:0] c0;
    logic        prev;
    int          n;
    wr(OFF_START_CFG, 16'h0000, 1'b0);
    c0 = counter0_value;
    repeat (20) @(negedge clk);
    cmp16(counter0_value - c0, 16'(20 / CT_TICK_DIV));
    wr(OFF_START_CFG, 16'h0010, 1'b0);
    repeat (4) @(negedge clk);
    c0 = counter0_value;
    repeat (5)
    begin
      counter0_ext_clk = 1'b1;
      repeat (2) @(negedge clk);
      counter0_ext_clk = 1'b0;
      repeat (2) @(negedge clk);
    end
    repeat (4) @(negedge clk);
    cmp16(counter0_value - c0, 16'h0005);
    n = 0;
    prev = counter2_out;
    repeat (64)
    begin
      @(negedge clk);
      if (counter2_out !== prev)
        n++;
      prev = counter2_out;
    end
    cmp_cnt(n, 8, 8);
  endtask

  initial
  begin
    failures  = 0;
    checks    = 0;
    rst_b     = 1'b0;
    bus_addr  = 5'h00;
    bus_wr    = 1'b0;
    bus_rd    = 1'b0;
    bus_word  = 1'b0;
    bus_wdata = 16'h0000;
    ext_trigger = 1'b0;
    slow      = 1'b0;
    counter0_ext_clk = 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    cmp16({4'h0, out0_code}, 16'h0000);
    cmp16({15'h0000, fifo_full}, 16'h0000);
    test_single();
    test_scan();
    test_outputs();
    test_trigger();
    test_counters();
    report_and_stop();
  end
endmodule
